// ### logic/stas_pkg.sv
// Shared constants, types and helpers of the terminal access sequencer
package stas_pkg;
    // Timing
    localparam int CLK_NS = 10;
    localparam int TERM_VALID_NS = 400;
    localparam int TERM_VALID_CYC = TERM_VALID_NS / CLK_NS;
    localparam int PHASE_W = 6;
    localparam logic [PHASE_W-1:0] MCT_ACK = 6'h2b;
    localparam logic [PHASE_W-1:0] MCT_HOLD = 6'h31;
    localparam logic [PHASE_W-1:0] SCT_LATCH = 6'h01;
    localparam logic [PHASE_W-1:0] SCT_CHECK = 6'h03;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 6'h3f;
    ////////////////////////////////////////////////////////////////////////////////
    // Terminal opcodes
    localparam logic [6:0] OP_FETCH = 7'h10;
    localparam logic [6:0] OP_READ = 7'h20;
    localparam logic [6:0] OP_READ_ONES = 7'h2f;
    localparam logic [6:0] MW_NOOP_A = 7'h40;
    localparam logic [6:0] MW_MODE_SET = 7'h41;
    localparam logic [6:0] MW_MODE_CLR = 7'h42;
    localparam logic [6:0] MW_ERR_CLR = 7'h43;
    localparam logic [6:0] MW_LOAD_IAR = 7'h44;
    localparam logic [6:0] MW_LOAD_PM = 7'h45;
    localparam logic [6:0] MW_PAR_CHK = 7'h46;
    localparam logic [6:0] MW_NOOP_B = 7'h47;
    localparam int OP_READ_BIT = 5;
    localparam logic [3:0] READ_ONES_LOW = 4'hf;
    ////////////////////////////////////////////////////////////////////////////////
    // Data bus layout
    localparam int TD_W = 24;
    localparam int DW_W = 23;
    localparam int TD_ADDR_LSB = 12;
    localparam int TD_MARK_LSB = 21;
    localparam logic [1:0] READ_MARK = 2'h3;
    localparam logic [11:0] READ_LOW_ZERO = 12'h000;
    localparam logic [TD_W-1:0] TD_ONES = 24'hff_ffff;
    localparam int IAR_W = 11;
    localparam int PM_W = 12;
    localparam int MR_STOP = 3;
    localparam int MR_DIRECT = 12;
    localparam int ESR_OP_PAR = 0;
    localparam int ESR_DATA_PAR = 1;
    ////////////////////////////////////////////////////////////////////////////////
    // Controller register map and fields
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_ANSWER = 8'h0c;
    localparam logic [7:0] A_REPLY_HI = 8'h10;
    localparam int CMD_TERM_LSB = 8;
    localparam int CMD_ADDR_LSB = 12;
    localparam int ST_ACK = 0;
    localparam int ST_PAR_ERR = 1;
    localparam int ST_SRC_ERR = 2;
    localparam int ST_TIMEOUT = 3;

    typedef enum logic [2:0] {C_IDLE, C_ALERT, C_WAIT, C_CHECK, C_DONE, C_HOLD} stas_cst_t;
    typedef enum logic [1:0] {T_IDLE, T_BUSY, T_NOACK} stas_tst_t;

    // Parity bit that makes a data word plus itself odd
    function automatic logic odd_par(input logic [DW_W-1:0] d);
        return ~(^d);
    endfunction

    // Scanner answer layout: reply 24..17 then 8..1, both reversed
    function automatic logic [15:0] scanner_answer_bus_format(input logic [TD_W-1:0] rr);
        logic [15:0] a;
        a = '0;
        for (int k = 0; k < 8; k++) begin
            a[k] = rr[TD_W-1-k];
            a[8+k] = rr[7-k];
        end
        return a;
    endfunction
endpackage

// ### logic/stas_link_if.sv
// Link between controller and one signaling terminal
interface stas_link_if;
    import stas_pkg::*;
    logic [7:0] opcode_bus;
    logic [15:0] terminal_select_strobe;
    logic terminal_enable;
    logic [TD_W-1:0] ctrl_td;
    logic ctrl_td_oe_n;
    logic [TD_W-1:0] term_td;
    logic term_td_oe_n;
    logic terminal_ack_lead;
    logic [3:0] ack_id;
    logic [TD_W-1:0] terminal_data_bus;

    // Undriven leads float high; drivers pull low
    assign terminal_data_bus = (ctrl_td_oe_n ? TD_ONES : ctrl_td)
        & (term_td_oe_n ? TD_ONES : term_td);

    modport ctrl (
        output opcode_bus, terminal_select_strobe, terminal_enable, ctrl_td, ctrl_td_oe_n,
        input terminal_ack_lead, ack_id, terminal_data_bus
    );
    modport term (
        input opcode_bus, terminal_select_strobe, terminal_enable, terminal_data_bus,
        output term_td, term_td_oe_n, terminal_ack_lead, ack_id
    );
endinterface

// ### logic/stas_phase.sv
// Clock phase counter for master and secondary timing
module stas_phase (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic clear,
    input wire logic run,
    // Phase
    output logic [stas_pkg::PHASE_W-1:0] phase
);
    import stas_pkg::*;

    typedef struct packed {
        logic [PHASE_W-1:0] count;
    } stas_phase_state_t;

    stas_phase_state_t s, next_s;

    // Saturates so a stuck sequence cannot wrap back into early phases
    always_comb begin
        next_s = s;
        if (clear) begin
            next_s.count = '0;
        end else if (run && s.count != PHASE_MAX) begin
            next_s.count = s.count + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign phase = s.count;
endmodule

// ### logic/stas_ctrl.sv
// Link controller end: AHB-Lite registers and terminal access sequencer
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
module stas_ctrl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Terminal link
    stas_link_if.ctrl link
);
    import stas_pkg::*;

    typedef struct packed {
        stas_cst_t st;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [6:0] opcode;
        logic [3:0] term;
        logic [8:0] addr;
        logic [TD_W-1:0] dreg;
        logic [TD_W-1:0] reply;
        logic [3:0] flags;
        logic [7:0] op_bus;
        logic [15:0] sel;
        logic enable;
        logic [TD_W-1:0] td;
        logic td_oe_n;
        logic mrun;
        logic mclr;
        logic srun;
        logic sclr;
    } stas_ctrl_state_t;

    stas_ctrl_state_t s, next_s;
    logic [PHASE_W-1:0] mphase;
    logic [PHASE_W-1:0] sphase;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase counters

    stas_phase u_master (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(s.mclr),
        .run(s.mrun),
        .phase(mphase)
    );

    stas_phase u_secondary (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(s.sclr),
        .run(s.srun),
        .phase(sphase)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_read_ones(input logic [6:0] op);
        return op[OP_READ_BIT] && op[3:0] == READ_ONES_LOW;
    endfunction

    function automatic logic is_mem_read(input logic [6:0] op);
        return op[OP_READ_BIT] && !is_read_ones(op);
    endfunction

    // Initialize and clear: releases every lead and empties the data register
    function automatic stas_ctrl_state_t teardown(input stas_ctrl_state_t x);
        x.st = C_IDLE;
        x.enable = 1'b0;
        x.sel = '0;
        x.op_bus = '0;
        x.td = '0;
        x.td_oe_n = 1'b1;
        x.dreg = '0;
        x.mrun = 1'b0;
        x.srun = 1'b0;
        return x;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [6:0] op;
        logic [8:0] ad;
        logic good;
        op = hwdata[6:0];
        ad = hwdata[CMD_ADDR_LSB +: 9];
        good = 1'b0;
        next_s = s;
        next_s.mclr = 1'b0;
        next_s.sclr = 1'b0;
        // Zero wait states: read data is registered at the address phase
        next_s.wr_pend = hsel && htrans[1] && hready && hwrite;
        next_s.wr_addr = haddr[7:0];
        next_s.hrdata = '0;
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                A_CMD: next_s.hrdata = {11'h000, s.addr, s.term, 1'b0, s.opcode};
                A_DATA: next_s.hrdata = {8'h00, s.dreg};
                A_STATUS: next_s.hrdata = {27'h000_0000, s.flags, s.st != C_IDLE};
                A_ANSWER: next_s.hrdata = {16'h0000, scanner_answer_bus_format(s.reply)};
                A_REPLY_HI: next_s.hrdata = {24'h00_0000, s.reply[TD_W-1:16]};
                default: next_s.hrdata = '0;
            endcase
        end
        // Register writes; a command while busy is dropped
        if (s.wr_pend) begin
            case (s.wr_addr)
                A_CMD: begin
                    if (s.st == C_IDLE) begin
                        next_s.opcode = op;
                        next_s.term = hwdata[CMD_TERM_LSB +: 4];
                        next_s.addr = ad;
                        next_s.st = C_ALERT;
                        next_s.mclr = 1'b1;
                        next_s.sclr = 1'b1;
                        next_s.mrun = 1'b1;
                        next_s.sel = 16'h0001 << hwdata[CMD_TERM_LSB +: 4];
                        next_s.op_bus = {^op, op};
                        if (op == OP_FETCH || is_read_ones(op)) begin
                            next_s.td_oe_n = 1'b1;
                        end else if (op[OP_READ_BIT]) begin
                            next_s.td = {~(^ad), READ_MARK, ad, READ_LOW_ZERO};
                            next_s.td_oe_n = 1'b0;
                        end else begin
                            next_s.td = {odd_par(s.dreg[DW_W-1:0]), s.dreg[DW_W-1:0]};
                            next_s.td_oe_n = 1'b0;
                        end
                    end
                end
                A_DATA: begin
                    if (s.st == C_IDLE) begin
                        next_s.dreg = hwdata[TD_W-1:0];
                    end
                end
                A_STATUS: next_s.flags = s.flags & ~hwdata[4:1];
                default: ;
            endcase
        end
        // Sequencer; flag sets come after the clear so they win
        case (s.st)
            C_IDLE: ;
            C_ALERT: begin
                next_s.enable = 1'b1;
                next_s.st = C_WAIT;
            end
            C_WAIT: begin
                if (link.terminal_ack_lead) begin
                    if (link.ack_id != s.term) begin
                        next_s.flags[ST_SRC_ERR] = 1'b1;
                        next_s.st = C_HOLD;
                    end else begin
                        next_s.srun = 1'b1;
                        next_s.st = C_CHECK;
                        if (is_mem_read(s.opcode)) begin
                            next_s.td_oe_n = 1'b1;
                        end
                    end
                end else if (mphase >= MCT_HOLD) begin
                    next_s.flags[ST_TIMEOUT] = 1'b1;
                    next_s = teardown(next_s);
                end
            end
            C_CHECK: begin
                // Latch one phase late so our own released drive has left the bus
                if (sphase == SCT_LATCH) begin
                    next_s.reply = link.terminal_data_bus;
                end
                if (sphase == SCT_CHECK) begin
                    good = is_read_ones(s.opcode) || (^s.reply);
                    if (good) begin
                        next_s.enable = 1'b0;
                        if (s.opcode == OP_FETCH) begin
                            next_s.st = C_DONE;
                        end else begin
                            next_s.flags[ST_ACK] = 1'b1;
                            next_s = teardown(next_s);
                        end
                    end else begin
                        next_s.flags[ST_PAR_ERR] = 1'b1;
                        next_s.st = C_HOLD;
                    end
                end
            end
            C_DONE: begin
                if (mphase >= MCT_ACK) begin
                    next_s.flags[ST_ACK] = 1'b1;
                    next_s = teardown(next_s);
                end
            end
            C_HOLD: begin
                if (mphase >= MCT_HOLD) begin
                    next_s = teardown(next_s);
                end
            end
            default: next_s = teardown(next_s);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.st <= C_IDLE;
            s.hreadyout <= 1'b1;
            s.td_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign link.opcode_bus = s.op_bus;
    assign link.terminal_select_strobe = s.sel;
    assign link.terminal_enable = s.enable;
    assign link.ctrl_td = s.td;
    assign link.ctrl_td_oe_n = s.td_oe_n;
endmodule

// ### logic/stas_term.sv
// Signaling terminal end: opcode decode, memories, list and maintenance writes
module stas_term #(
    parameter logic [3:0] TERM_ID = 4'h0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Terminal link
    stas_link_if.term link,
    // Data memory load port
    input wire logic dm_we,
    input wire logic [8:0] dm_addr,
    input wire logic [stas_pkg::DW_W-1:0] dm_wdata,
    // Terminal state
    output logic [stas_pkg::DW_W-1:0] mode_reg,
    output logic [stas_pkg::IAR_W-1:0] instruction_address_register,
    output logic [20:0] error_source,
    output logic [8:0] list_ptr
);
    import stas_pkg::*;

    typedef struct packed {
        stas_tst_t st;
        logic ack;
        logic [TD_W-1:0] td;
        logic td_oe_n;
        logic [6:0] op;
        logic [PHASE_W-1:0] cnt;
        logic [8:0] list_ptr;
        logic [DW_W-1:0] mr;
        logic [IAR_W-1:0] instruction_address_register;
        logic [20:0] esr;
    } stas_term_state_t;

    stas_term_state_t s, next_s;
    logic [DW_W-1:0] dm [512];
    logic [PM_W-1:0] pm [2048];
    logic pm_we;

    always_comb begin
        logic [TD_W-1:0] bus;
        logic [DW_W-1:0] word;
        logic ok;
        bus = link.terminal_data_bus;
        word = '0;
        ok = 1'b1;
        pm_we = 1'b0;
        next_s = s;
        case (s.st)
            T_IDLE: begin
                if (link.terminal_enable && link.terminal_select_strobe[TERM_ID]) begin
                    next_s.op = link.opcode_bus[6:0];
                    next_s.cnt = '0;
                    if (^link.opcode_bus) begin
                        next_s.esr[ESR_OP_PAR] = 1'b1;
                        ok = 1'b0;
                    end else begin
                        case (link.opcode_bus[6:0])
                            OP_FETCH, OP_READ, OP_READ_ONES: ;
                            MW_MODE_SET: next_s.mr = s.mr | bus[DW_W-1:0];
                            MW_MODE_CLR: next_s.mr = s.mr & ~bus[DW_W-1:0];
                            MW_ERR_CLR: next_s.esr = '0;
                            MW_LOAD_IAR: begin
                                ok = s.mr[MR_STOP];
                                if (ok) begin
                                    next_s.instruction_address_register = s.mr[MR_DIRECT] ? bus[IAR_W-1:0]
                                        : pm[s.instruction_address_register][IAR_W-1:0];
                                end
                            end
                            MW_LOAD_PM: begin
                                ok = s.mr[MR_STOP];
                                pm_we = ok;
                                if (ok) begin
                                    next_s.instruction_address_register = s.instruction_address_register + 1'b1;
                                end
                            end
                            MW_NOOP_A, MW_NOOP_B: ;
                            MW_PAR_CHK: begin
                                ok = ^bus;
                                next_s.esr[ESR_DATA_PAR] = s.esr[ESR_DATA_PAR] | ~ok;
                            end
                            default: begin
                                if (link.opcode_bus[OP_READ_BIT]) begin
                                    ok = 1'b1;
                                end else begin
                                    ok = 1'b0;
                                end
                            end
                        endcase
                    end
                    if (ok) begin
                        next_s.ack = 1'b1;
                        next_s.st = T_BUSY;
                        if (link.opcode_bus[6:0] == OP_FETCH) begin
                            word = dm[s.list_ptr];
                            next_s.td = {odd_par(word), word};
                            next_s.td_oe_n = 1'b0;
                        end else if (link.opcode_bus[OP_READ_BIT]) begin
                            word = dm[bus[TD_ADDR_LSB +: 9]];
                            next_s.td = link.opcode_bus[3:0] == READ_ONES_LOW ? TD_ONES
                                : {odd_par(word), word};
                            next_s.td_oe_n = 1'b0;
                        end
                    end else begin
                        next_s.st = T_NOACK;
                    end
                end
            end
            T_BUSY: begin
                if (s.cnt != PHASE_MAX) begin
                    next_s.cnt = s.cnt + 1'b1;
                end
                if (!link.terminal_enable) begin
                    next_s.ack = 1'b0;
                    next_s.td_oe_n = 1'b1;
                    next_s.st = T_IDLE;
                    // A late enable drop means the controller saw an error
                    if (s.op == OP_FETCH && s.cnt < PHASE_W'(TERM_VALID_CYC)) begin
                        next_s.list_ptr = s.list_ptr + 1'b1;
                    end
                end
            end
            T_NOACK: begin
                if (!link.terminal_enable) begin
                    next_s.st = T_IDLE;
                end
            end
            default: next_s.st = T_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.st <= T_IDLE;
            s.td_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Memories carry no reset; software loads them before use
    always_ff @(posedge hclk) begin
        if (pm_we) begin
            pm[s.instruction_address_register] <= link.terminal_data_bus[PM_W-1:0];
        end
        if (dm_we) begin
            dm[dm_addr] <= dm_wdata;
        end
    end

    assign link.terminal_ack_lead = s.ack;
    assign link.ack_id = TERM_ID;
    assign link.term_td = s.td;
    assign link.term_td_oe_n = s.td_oe_n;
    assign mode_reg = s.mr;
    assign instruction_address_register = s.instruction_address_register;
    assign error_source = s.esr;
    assign list_ptr = s.list_ptr;
endmodule

// ### verif/stas_assertions.sv
// Link protocol checker for the terminal access sequencer
module stas_assertions import stas_pkg::*; (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link from the controller
    input wire logic [7:0] opcode_bus,
    input wire logic [15:0] terminal_select_strobe,
    input wire logic terminal_enable,
    input wire logic [stas_pkg::TD_W-1:0] ctrl_td,
    input wire logic ctrl_td_oe_n,
    // Link from the terminal
    input wire logic terminal_ack_lead
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_op;
    logic ones_op;
    assign rd_op = opcode_bus[OP_READ_BIT] & (opcode_bus[3:0] != READ_ONES_LOW);
    assign ones_op = opcode_bus[OP_READ_BIT] & (opcode_bus[3:0] == READ_ONES_LOW);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_ack;
        $rose(terminal_ack_lead);
    endsequence
    // Ack never came: the sequence must stay up for the failure window
    sequence s_no_ack;
        $rose(terminal_enable) ##3 !terminal_ack_lead;
    endsequence
    chk_fetch_no_data: assert property (
        terminal_enable && opcode_bus[6:0] == OP_FETCH |-> ctrl_td_oe_n) else $error("fetch drove bus");
    chk_enable_after_bus: assert property (
        $rose(terminal_enable) |-> $past(|terminal_select_strobe)) else $error("enable before select");
    chk_opcode_even_par: assert property (
        |terminal_select_strobe |-> !(^opcode_bus)) else $error("opcode parity odd");
    chk_read_word_form: assert property (
        rd_op && !ctrl_td_oe_n |-> ctrl_td[11:0] == READ_LOW_ZERO && ctrl_td[22:21] == READ_MARK
        && ctrl_td[23] == ~^ctrl_td[20:12]) else $error("read word malformed");
    chk_ones_undriven: assert property (
        ones_op && terminal_enable |-> ctrl_td_oe_n) else $error("read ones drove bus");
    chk_read_release: assert property (
        rd_op ##0 s_ack |-> ##[1:2] ctrl_td_oe_n) else $error("bus kept after read ack");
    chk_fast_drop: assert property (
        s_ack |-> ##[1:39] !terminal_enable) else $error("enable not dropped in time");
    chk_no_ack_hold: assert property (
        s_no_ack |-> terminal_enable[*8]) else $error("enable dropped without ack");
endmodule

// ### verif/stas_tb_top.sv
// Self-checking bench joining controller and terminal
module stas_tb_top import stas_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic dm_we = 1'b0;
    logic [8:0] dm_addr = '0;
    logic [DW_W-1:0] dm_wdata = '0;
    logic [DW_W-1:0] mode_reg;
    logic [IAR_W-1:0] instruction_address_register;
    logic [20:0] error_source;
    logic [8:0] list_ptr;
    int err_total = 0;
    int checks = 0;
    always #5 hclk = ~hclk;
    stas_link_if link();
    stas_ctrl u_stas_ctrl(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(link.ctrl));
    stas_term #(.TERM_ID(4'h0)) u_stas_term(.hclk(hclk), .hresetn(hresetn), .link(link.term),
        .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .mode_reg(mode_reg),
        .instruction_address_register(instruction_address_register), .error_source(error_source), .list_ptr(list_ptr));
    stas_assertions u_stas_assertions(.hclk(hclk), .hresetn(hresetn),
        .opcode_bus(link.opcode_bus), .terminal_select_strobe(link.terminal_select_strobe),
        .terminal_enable(link.terminal_enable), .ctrl_td(link.ctrl_td),
        .ctrl_td_oe_n(link.ctrl_td_oe_n), .terminal_ack_lead(link.terminal_ack_lead));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded so a stuck slave ends the run instead of hanging it
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n > 50) begin
                err_total++;
                summarize();
            end
        end while (hreadyout !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        check(what, r, exp);
    endtask
    // Issues one sequence and waits for busy to clear, then clears sticky status
    task automatic cmd(input logic [6:0] op, input logic [3:0] t, input logic [8:0] a,
        input logic [23:0] d, input logic ok);
        logic [31:0] r;
        int n;
        // Fetch and read carry only the instruction word
        if (op != OP_FETCH && !op[OP_READ_BIT]) begin
            ahb(1'b1, A_DATA, {8'h00, d}, r);
        end
        ahb(1'b1, A_CMD, {11'h000, a, t, 1'b0, op}, r);
        n = 0;
        r = 32'h0000_0001;
        while (r[0] !== 1'b0) begin
            ahb(1'b0, A_STATUS, 32'h0000_0000, r);
            n++;
            if (n > 100) begin
                err_total++;
                summarize();
            end
        end
        check("status ack", {31'h0, r[1]}, {31'h0, ok});
        check("status timeout", {31'h0, r[4]}, {31'h0, !ok});
        ahb(1'b1, A_STATUS, 32'h0000_001e, r);
    endtask
    task automatic reply_chk(input logic [23:0] rr);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = {<<{rr[7:0]}};
        hi = {<<{rr[23:16]}};
        rd_chk("answer", A_ANSWER, {16'h0000, lo, hi});
        rd_chk("reply hi", A_REPLY_HI, {24'h00_0000, rr[23:16]});
    endtask
    task automatic dm_load(input logic [8:0] a, input logic [DW_W-1:0] d);
        dm_we <= 1'b1;
        dm_addr <= a;
        dm_wdata <= d;
        @(posedge hclk);
        dm_we <= 1'b0;
        @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_fetch();
        dm_load(9'h000, 23'h51_2a3c);
        cmd(OP_FETCH, 4'h0, 9'h000, 24'h00_0000, 1'b1);
        reply_chk({~^23'h51_2a3c, 23'h51_2a3c});
        check("list ptr", {23'h0, list_ptr}, 32'h0000_0001);
        cmd(OP_FETCH, 4'h3, 9'h000, 24'h00_0000, 1'b0);
        rd_chk("cmd", A_CMD, {11'h000, 9'h000, 4'h3, 1'b0, OP_FETCH});
    endtask
    task automatic run_read();
        dm_load(9'h1a5, 23'h2b_cd01);
        cmd(OP_READ, 4'h0, 9'h1a5, 24'h00_0000, 1'b1);
        reply_chk({~^23'h2b_cd01, 23'h2b_cd01});
        cmd(OP_READ_ONES, 4'h0, 9'h000, 24'h00_0000, 1'b1);
        reply_chk(24'hff_ffff);
        rd_chk("unmapped", 8'h20, 32'h0000_0000);
    endtask
    task automatic run_maint();
        logic [6:0] ops[4] = '{MW_NOOP_A, MW_NOOP_B, MW_PAR_CHK, MW_ERR_CLR};
        cmd(MW_MODE_SET, 4'h0, 9'h000, 24'h00_1008, 1'b1);
        cmd(MW_LOAD_IAR, 4'h0, 9'h000, 24'h00_0005, 1'b1);
        cmd(MW_LOAD_PM, 4'h0, 9'h000, 24'h00_0abc, 1'b1);
        check("iar", {21'h0, instruction_address_register}, 32'h0000_0006);
        cmd(MW_MODE_CLR, 4'h0, 9'h000, 24'h00_0008, 1'b1);
        cmd(MW_LOAD_IAR, 4'h0, 9'h000, 24'h00_0002, 1'b0);
        check("iar kept", {21'h0, instruction_address_register}, 32'h0000_0006);
        foreach (ops[i]) begin
            cmd(ops[i], 4'h0, 9'h000, 24'hff_ffff, 1'b1);
            check("mode", {9'h0, mode_reg}, 32'h0000_1000);
        end
        check("errors", {11'h0, error_source}, 32'h0000_0000);
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        run_fetch();
        run_read();
        run_maint();
        summarize();
    end
endmodule
